// File: design/tcr_ctrl.sv
// timer control registers: clock source, waveform mode, pin override, event routing
//
// How it works
// RL1 - clock code zero stops, codes one to seven divide clock
// RL2 - code top bit set counts on event channel
// RL3 - software picks undivided clock for high resolution
// RL4 - enabled channel drives pin in waveform modes
// RL5 - capture action turns enables into capture enables
// RL6 - normal mode: no waveform, period top, top events
// RL7 - frequency and single ramp decode; two codes reserved
// RL8 - dual ramp modes: bottom update, chosen wrap points
// RL9 - waveform reaches pin only with enable set
// RL10 - forced output writes set levels while stopped
// RL11 - event action field decodes seven actions
// RL12 - capture action makes error flag mean overflow
// RL13 - event delay adds exactly one clock
// RL14 - source code zero none, top bit picks channel
// RL15 - capture channels take events n to n+3
// RL16 - events act only with a non-none action
// RL17 - reserved bits read zero, written as zero
// RL18 - prescaler gives one-cycle enable; stopped counter holds
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
module tcr_ctrl
  import tcr_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [7:0]        event_chan_i,
  input  wire logic [3:0]        port_out_i,
  input  wire logic [3:0]        wave_next_i,
  input  wire logic              at_top_i,
  input  wire logic              at_bottom_i,
  input  wire logic              capture_buffer_overflow_i,
  output logic                   count_enable_o,
  output tcr_mode_t              mode_o,
  output logic                   capture_mode_o,
  output logic      [2:0]        event_action_o,
  output logic                   action_event_o,
  output logic      [3:0]        capture_event_o,
  output logic      [3:0]        pin_out_o,
  output logic      [3:0]        pin_override_o,
  output logic      [3:0]        wave_level_o,
  output logic                   wrap_event_o,
  output logic                   irq_o
);

  // ---------------- register state ----------------
  logic [3:0]            clock_source_select_q, clock_source_select_d;    // clock source code
  logic [3:0]            channel_output_enable_q, channel_output_enable_d; // per channel enables
  logic [2:0]            waveform_mode_q, waveform_mode_d;               // waveform mode code
  logic [2:0]            event_action_q, event_action_d;                 // event action code
  logic                  event_delay_q, event_delay_d;                   // one-cycle event delay
  logic [3:0]            event_source_select_q, event_source_select_d;   // event source code
  logic [NUM_FLAGS-1:0]  status_q, status_d;                             // sticky flags
  logic [NUM_FLAGS-1:0]  mask_q, mask_d;                                 // interrupt mask
  logic                  ack_q, ack_d;                                   // bus acknowledge
  logic [31:0]           rdat_q, rdat_d;                                 // read data
  tcr_wb_req_t           req;                                            // bundled bus request
  logic                  take;                                           // request accepted now
  logic                  wr_lane0;                                       // write into the low byte
  logic [ADR_W-3:0]      idx;                                            // register index
  logic [7:0]            wbyte;                                          // written byte

  // ---------------- derived state ----------------
  logic                  stopped;       // clock code is off
  logic                  cap_mode;      // a capture action is selected
  tcr_mode_t             mode_dec;      // decoded waveform mode
  logic                  presc_tick;    // prescaler enable
  logic [3:0]            wave_q, wave_d;                 // waveform output levels
  logic                  cnt_en_q, cnt_en_d;             // count enable
  logic [7:0]            ev_prev_q;                      // events one cycle late
  logic [7:0]            ev_use;                         // events after optional delay
  logic                  act_ev_q, act_ev_d;             // action event
  logic [3:0]            cap_ev_q, cap_ev_d;             // per channel capture events
  logic [3:0]            pin_q, pin_d;                   // pin output value
  logic [3:0]            ovr_q, ovr_d;                   // pin override
  logic                  wrap_q, wrap_d;                 // wrap event pulse
  logic                  irq_q, irq_d;                   // interrupt level
  tcr_mode_t             mode_q;                         // registered decode
  logic                  cap_mode_q;                     // registered capture mode

  always_comb begin
    req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
  end

  // a new request is taken only while no answer stands, so each access acks exactly once
  assign take     = req.cyc && req.stb && !ack_q;
  assign wr_lane0 = take && req.we && req.sel[0];
  assign idx      = req.adr[ADR_W-1:2];
  assign wbyte    = req.dat[7:0];
  assign stopped  = (clock_source_select_q == CLK_OFF);
  assign cap_mode = is_capture(event_action_q);
  assign mode_dec = mode_decode(waveform_mode_q);

  // ---------------- bus and register file ----------------
  // next values of the bus slave and of the control and mask registers
  always_comb begin
    clock_source_select_d   = clock_source_select_q;
    channel_output_enable_d = channel_output_enable_q;
    waveform_mode_d         = waveform_mode_q;
    event_action_d          = event_action_q;
    event_delay_d           = event_delay_q;
    event_source_select_d   = event_source_select_q;
    mask_d                  = mask_q;
    ack_d                   = take;
    rdat_d                  = 32'h0000_0000;
    if (wr_lane0) begin
      // reserved bits are simply not stored, so they read back as zero
      case (idx)
        3'(IDX_CLK_SRC):   clock_source_select_d = wbyte[CLOCK_SOURCE_SELECT_LSB +: 4];         // RL17
        3'(IDX_CHEN_WAVE): begin
          channel_output_enable_d = wbyte[CHEN_LSB +: 4];
          waveform_mode_d         = wbyte[WMODE_LSB +: 3];                          // RL17
        end
        3'(IDX_EVENT_CTL): begin
          event_action_d        = wbyte[EVENT_ACTION_LSB +: 3];
          event_delay_d         = wbyte[EVENT_DELAY_BIT];
          event_source_select_d = wbyte[EVENT_SOURCE_SELECT_LSB +: 4];
        end
        3'(IDX_IRQ_MASK):  mask_d = wbyte[NUM_FLAGS-1:0];
        default:           mask_d = mask_q;
      endcase
    end
    if (take && !req.we) begin
      // unmapped indices answer with zero data
      case (idx)
        3'(IDX_CLK_SRC):   rdat_d[CLOCK_SOURCE_SELECT_LSB +: 4] = clock_source_select_q;        // RL17
        3'(IDX_CHEN_WAVE): begin
          rdat_d[CHEN_LSB +: 4]  = channel_output_enable_q;
          rdat_d[WMODE_LSB +: 3] = waveform_mode_q;
        end
        3'(IDX_FORCE_OUT): rdat_d[FORCE_LSB +: 4] = wave_q;
        3'(IDX_EVENT_CTL): begin
          rdat_d[EVENT_ACTION_LSB +: 3] = event_action_q;
          rdat_d[EVENT_DELAY_BIT]      = event_delay_q;
          rdat_d[EVENT_SOURCE_SELECT_LSB +: 4] = event_source_select_q;
        end
        3'(IDX_IRQ_STAT):  rdat_d[NUM_FLAGS-1:0] = status_q;
        3'(IDX_IRQ_MASK):  rdat_d[NUM_FLAGS-1:0] = mask_q;
        default:           rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clock_source_select_q   <= CLOCK_SOURCE_SELECT_RST;
      channel_output_enable_q <= REG_RST[3:0];
      waveform_mode_q         <= WM_NORMAL;
      event_action_q          <= EA_NONE;
      event_delay_q           <= 1'b0;
      event_source_select_q   <= REG_RST[3:0];
      mask_q                  <= '0;
      ack_q                   <= 1'b0;
      rdat_q                  <= 32'h0000_0000;
    end else begin
      clock_source_select_q   <= clock_source_select_d;
      channel_output_enable_q <= channel_output_enable_d;
      waveform_mode_q         <= waveform_mode_d;
      event_action_q          <= event_action_d;
      event_delay_q           <= event_delay_d;
      event_source_select_q   <= event_source_select_d;
      mask_q                  <= mask_d;
      ack_q                   <= ack_d;
      rdat_q                  <= rdat_d;
    end
  end

  // ---------------- counter clock ----------------
  tcr_prescaler #(
    .PW (PRESC_W)
  ) u_presc (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .div_code (clock_source_select_q[2:0]),
    .tick     (presc_tick)
  );

  // count enable from prescaler or event channel; the high-resolution path needs the undivided code
  always_comb begin
    if (clock_source_select_q[3]) begin
      cnt_en_d = event_chan_i[clock_source_select_q[2:0]];                       // RL2
    end else if (stopped) begin
      cnt_en_d = 1'b0;                                                            // RL18
    end else begin
      cnt_en_d = presc_tick;                                                      // RL1
    end
  end

  // ---------------- event routing ----------------
  // the delay stage lines up a cascaded counter's carry with our own count
  always_comb begin
    ev_use   = event_delay_q ? ev_prev_q : event_chan_i;                          // RL13
    act_ev_d = 1'b0;
    cap_ev_d = 4'h0;
    // code zero and the reserved codes select no source
    if (event_source_select_q[3] && (event_action_q != EA_NONE)) begin            // RL14 RL16
      act_ev_d = ev_use[event_source_select_q[2:0]];                              // RL11
      if (cap_mode) begin
        for (int k = 0; k < 4; k++) begin
          cap_ev_d[k] = channel_output_enable_q[k]
                        && ev_use[3'(event_source_select_q[2:0] + 3'(k))];        // RL5 RL15
        end
      end
    end
  end

  // ---------------- waveform levels and pins ----------------
  // while stopped software owns the levels; while running the core does
  always_comb begin
    wave_d = stopped ? wave_q : wave_next_i;
    if (stopped && wr_lane0 && (idx == 3'(IDX_FORCE_OUT))) begin
      wave_d = wbyte[FORCE_LSB +: 4];                                             // RL10
    end
    for (int k = 0; k < 4; k++) begin
      // the pin direction stays with software; only the output value is taken over
      ovr_d[k] = mode_dec.wave_on && channel_output_enable_q[k] && !cap_mode;     // RL4 RL9
      pin_d[k] = ovr_d[k] ? wave_q[k] : port_out_i[k];                            // RL6
    end
  end

  // ---------------- flags and interrupt ----------------
  // set wins over a write-one clear arriving in the same cycle
  always_comb begin
    wrap_d = cnt_en_q && ((mode_dec.ovf_top && at_top_i) || (mode_dec.ovf_bot && at_bottom_i)); // RL7 RL8
    status_d = status_q;
    if (take && req.we && req.sel[0] && (idx == 3'(IDX_IRQ_STAT))) begin
      status_d = status_q & ~wbyte[NUM_FLAGS-1:0];
    end
    if (wrap_d) begin
      status_d[FLAG_WRAP] = 1'b1;
    end
    if (cap_mode && capture_buffer_overflow_i) begin
      status_d[FLAG_COVF] = 1'b1;                                                 // RL12
    end
    irq_d = |(status_d & mask_d);
  end

  // registers of the datapath groups
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_en_q   <= 1'b0;
      ev_prev_q  <= 8'h00;
      act_ev_q   <= 1'b0;
      cap_ev_q   <= 4'h0;
      wave_q     <= 4'h0;
      pin_q      <= 4'h0;
      ovr_q      <= 4'h0;
      wrap_q     <= 1'b0;
      status_q   <= '0;
      irq_q      <= 1'b0;
      mode_q     <= '0;
      cap_mode_q <= 1'b0;
    end else begin
      cnt_en_q   <= cnt_en_d;
      ev_prev_q  <= event_chan_i;
      act_ev_q   <= act_ev_d;
      cap_ev_q   <= cap_ev_d;
      wave_q     <= wave_d;
      pin_q      <= pin_d;
      ovr_q      <= ovr_d;
      wrap_q     <= wrap_d;
      status_q   <= status_d;
      irq_q      <= irq_d;
      mode_q     <= mode_dec;
      cap_mode_q <= cap_mode;
    end
  end

  // every output straight from a flip-flop
  assign wb_dat_o        = rdat_q;
  assign wb_ack_o        = ack_q;
  assign count_enable_o  = cnt_en_q;
  assign mode_o          = mode_q;
  assign capture_mode_o  = cap_mode_q;
  assign event_action_o  = event_action_q;
  assign action_event_o  = act_ev_q;
  assign capture_event_o = cap_ev_q;
  assign pin_out_o       = pin_q;
  assign pin_override_o  = ovr_q;
  assign wave_level_o    = wave_q;
  assign wrap_event_o    = wrap_q;
  assign irq_o           = irq_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_off_no_count: assert property (stopped |=> !cnt_en_q) // RL18
    else $error("count enable while clock source off");
  a_div1_every: assert property ((clock_source_select_q == CLK_DIV1) |=> cnt_en_q) // RL1
    else $error("undivided clock missed a count enable");
  a_event_clock: assert property (clock_source_select_q[3]
      |=> cnt_en_q == $past(event_chan_i[clock_source_select_q[2:0]])) // RL2
    else $error("event clock source not followed");
  a_pin_override: assert property ((mode_dec.wave_on && channel_output_enable_q[0] && !cap_mode)
      |=> ovr_q[0] && (pin_q[0] == $past(wave_q[0]))) // RL4
    else $error("waveform not driven to pin");
  a_capture_no_pin: assert property (cap_mode |=> ovr_q == 4'h0) // RL5
    else $error("pin overridden during capture");
  a_normal_mode: assert property ((waveform_mode_q == WM_NORMAL)
      |=> !mode_q.wave_on && !mode_q.top_cca && mode_q.ovf_top && !mode_q.ovf_bot) // RL6
    else $error("normal mode decode wrong");
  a_dual_both: assert property ((waveform_mode_q == WM_DUAL_BOTH)
      |=> mode_q.ovf_top && mode_q.ovf_bot && mode_q.upd_bot && mode_q.dual) // RL8
    else $error("dual ramp both decode wrong");
  a_force_stopped: assert property ((stopped && wr_lane0 && idx == 3'(IDX_FORCE_OUT))
      |=> wave_q == $past(wbyte[3:0])) // RL10
    else $error("forced output not applied while stopped");
  a_delay_one: assert property ((event_delay_q && event_source_select_q[3] && event_action_q != EA_NONE)
      |=> act_ev_q == $past(ev_prev_q[event_source_select_q[2:0]])) // RL13
    else $error("delayed event not one cycle late");
  a_none_action: assert property ((event_action_q == EA_NONE) |=> !act_ev_q && cap_ev_q == 4'h0) // RL16
    else $error("event acted with no action");
  a_capture_map: assert property ((cap_mode && !event_delay_q && channel_output_enable_q[3]
      && event_source_select_q[3])
      |=> cap_ev_q[3] == $past(event_chan_i[3'(event_source_select_q[2:0] + 3'h3)])) // RL15
    else $error("capture channel d mapped wrong");
  a_cap_overflow: assert property ((cap_mode && capture_buffer_overflow_i) |=> status_q[FLAG_COVF]) // RL12
    else $error("capture overflow not flagged");
  // single ramp wraps at bottom only; this checks that a bottom strobe raises the wrap pulse
  a_single_wrap: assert property ((waveform_mode_q == WM_SINGLE) && cnt_en_q && at_bottom_i |=> wrap_q) // RL7
    else $error("single ramp missed bottom wrap");
  // code zero and the reserved source codes must stay silent whatever the action
  a_no_source: assert property (!event_source_select_q[3] |=> !act_ev_q && cap_ev_q == 4'h0) // RL14
    else $error("event acted with no source selected");

  // the main scenarios that the bench is expected to reach
  c_event_count: cover property (clock_source_select_q[3] ##1 cnt_en_q);
  c_capture_hit: cover property (cap_mode ##1 cap_ev_q != 4'h0);
  c_irq_raised:  cover property (!irq_q ##1 irq_q);
  c_wrap_bottom: cover property (mode_q.ovf_bot && wrap_q);
  c_force_write: cover property (stopped && wr_lane0 && idx == 3'(IDX_FORCE_OUT));

endmodule

// File: design/tcr_pkg.sv
// shared constants, types and decode functions of the timer control registers
package tcr_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam int unsigned IDX_CLK_SRC   = 0;  // clock_source_control
  localparam int unsigned IDX_CHEN_WAVE = 1;  // channel_enable_wave_mode
  localparam int unsigned IDX_FORCE_OUT = 2;  // compare_output_force
  localparam int unsigned IDX_EVENT_CTL = 3;  // event_control
  localparam int unsigned IDX_IRQ_STAT  = 4;  // sticky event flags, write one to clear
  localparam int unsigned IDX_IRQ_MASK  = 5;  // interrupt mask, same layout
  localparam int unsigned ADR_W         = 5;  // byte address width on the bus

  // field layout
  localparam int unsigned CLOCK_SOURCE_SELECT_LSB = 0;
  localparam int unsigned CHEN_LSB   = 4;
  localparam int unsigned WMODE_LSB  = 0;
  localparam int unsigned FORCE_LSB  = 0;
  localparam int unsigned EVENT_SOURCE_SELECT_LSB  = 0;
  localparam int unsigned EVENT_DELAY_BIT  = 4;
  localparam int unsigned EVENT_ACTION_LSB  = 5;
  localparam int unsigned FLAG_WRAP  = 0;  // wrap_flag
  localparam int unsigned FLAG_COVF  = 1;  // capture_overflow_flag
  localparam int unsigned NUM_FLAGS  = 2;

  // reset values
  localparam logic [3:0] CLOCK_SOURCE_SELECT_RST = 4'h0;
  localparam logic [7:0] REG_RST    = 8'h00;

  // clock source codes
  localparam logic [3:0] CLK_OFF  = 4'h0;
  localparam logic [3:0] CLK_DIV1 = 4'h1;

  // waveform mode codes
  localparam logic [2:0] WM_NORMAL    = 3'h0;
  localparam logic [2:0] WM_FREQ      = 3'h1;
  localparam logic [2:0] WM_SINGLE    = 3'h3;
  localparam logic [2:0] WM_DUAL_TOP  = 3'h5;
  localparam logic [2:0] WM_DUAL_BOTH = 3'h6;
  localparam logic [2:0] WM_DUAL_BOT  = 3'h7;

  // event action codes
  localparam logic [2:0] EA_NONE    = 3'h0;
  localparam logic [2:0] EA_CAPTURE = 3'h1;
  localparam logic [2:0] EA_UPDOWN  = 3'h2;
  localparam logic [2:0] EA_QUADRATURE_DECODE    = 3'h3;
  localparam logic [2:0] EA_RESTART = 3'h4;
  localparam logic [2:0] EA_FREQCAP = 3'h5;
  localparam logic [2:0] EA_PWCAP   = 3'h6;

  localparam int unsigned PRESC_W = 10;  // enough for divide by 1024

  // decoded waveform mode, handed to the counter core
  typedef struct packed {
    logic wave_on;   // a waveform is generated
    logic top_cca;   // top is channel_a_compare, else period_value
    logic upd_top;   // buffered update at top
    logic upd_bot;   // buffered update at bottom
    logic ovf_top;   // wrap flag and event at top
    logic ovf_bot;   // wrap flag and event at bottom
    logic dual;      // counts up then down
  } tcr_mode_t;

  // bus request bundle
  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADR_W-1:0]  adr;
    logic [3:0]        sel;
    logic [31:0]       dat;
  } tcr_wb_req_t;

  // waveform mode decode; reserved codes generate nothing and raise no flag
  function automatic tcr_mode_t mode_decode(input logic [2:0] wm);
    tcr_mode_t m;
    m = '0;
    case (wm)
      WM_NORMAL:    begin m.upd_top = 1'b1; m.ovf_top = 1'b1; end
      WM_FREQ:      begin m.wave_on = 1'b1; m.top_cca = 1'b1; m.upd_top = 1'b1; m.ovf_top = 1'b1; end
      WM_SINGLE:    begin m.wave_on = 1'b1; m.upd_bot = 1'b1; m.ovf_bot = 1'b1; end
      WM_DUAL_TOP:  begin m.wave_on = 1'b1; m.dual = 1'b1; m.upd_bot = 1'b1; m.ovf_top = 1'b1; end
      WM_DUAL_BOTH: begin m.wave_on = 1'b1; m.dual = 1'b1; m.upd_bot = 1'b1; m.ovf_top = 1'b1; m.ovf_bot = 1'b1; end
      WM_DUAL_BOT:  begin m.wave_on = 1'b1; m.dual = 1'b1; m.upd_bot = 1'b1; m.ovf_bot = 1'b1; end
      default:      m = '0;
    endcase
    return m;
  endfunction

  // true for the three capture actions
  function automatic logic is_capture(input logic [2:0] ea);
    return (ea == EA_CAPTURE) || (ea == EA_FREQCAP) || (ea == EA_PWCAP);
  endfunction

  // prescaler mask: a tick when all masked counter bits are ones
  function automatic logic [PRESC_W-1:0] div_mask(input logic [2:0] code);
    case (code)
      3'h1:    return 10'h000;
      3'h2:    return 10'h001;
      3'h3:    return 10'h003;
      3'h4:    return 10'h007;
      3'h5:    return 10'h03f;
      3'h6:    return 10'h0ff;
      3'h7:    return 10'h3ff;
      default: return 10'h000;
    endcase
  endfunction

endpackage

// File: design/tcr_prescaler.sv
// free-running prescaler giving one-cycle count enables
`timescale 1ns/100ps
module tcr_prescaler
  import tcr_pkg::*;
#(
  parameter int unsigned PW = PRESC_W  // counter width
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [2:0] div_code,
  output logic            tick
);

  // the division table needs ten bits of counter, so any other width is refused at elaboration
  if (PW != PRESC_W) begin : g_bad_width
    $error("tcr_prescaler: width must equal PRESC_W");
  end

  logic [PW-1:0] cnt_q;  // running count
  logic [PW-1:0] cnt_d;  // next count

  // counting never stops, so a changed divider takes effect at once with a short first period
  always_comb begin
    cnt_d = cnt_q + 10'h001;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // a tick once every divided period
  always_comb begin
    tick = ((cnt_q & div_mask(div_code)) == div_mask(div_code));
  end

endmodule

// File: tb/tcr_partner.sv
// model of the event routing network and the port output register
`timescale 1ns/100ps
module tcr_partner
  import tcr_pkg::*;
(
  input  wire logic       mclk,
  output logic      [7:0] event_chan,
  output logic      [3:0] port_out
);
  // port register holds a fixed pattern so an override is visible
  initial begin
    event_chan = 8'h00;
    port_out   = 4'h5;
  end
  // one event on channel n for exactly one clock, like the routing network
  task automatic pulse(input int n);
    @(posedge mclk);
    event_chan <= 8'h01 << n;
    @(posedge mclk);
    event_chan <= 8'h00;
  endtask
endmodule

// File: tb/test_tcr_ctrl.sv
// self-checking bench of the timer control registers
`timescale 1ns/100ps
module test_tcr_ctrl import tcr_pkg::*;;
  logic        mclk, rst_b, top, bot, covf, ack, cen, capm, aev, wrap, irq;
  tcr_wb_req_t req;           // bus request bundle
  logic [31:0] rdat, q;       // read data and last captured word
  logic [7:0]  ev;            // event channels
  logic [3:0]  port, wnext, pin, ovr, wlev, cev;
  logic [2:0]  eact;
  tcr_mode_t   mode;
  int          bad_count, samples_checked, cyc_n;
  tcr_partner p (.mclk(mclk), .event_chan(ev), .port_out(port));
  tcr_ctrl dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
    .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .event_chan_i(ev), .port_out_i(port), .wave_next_i(wnext), .at_top_i(top), .at_bottom_i(bot),
    .capture_buffer_overflow_i(covf), .count_enable_o(cen), .mode_o(mode), .capture_mode_o(capm),
    .event_action_o(eact), .action_event_o(aev), .capture_event_o(cev), .pin_out_o(pin),
    .pin_override_o(ovr), .wave_level_o(wlev), .wrap_event_o(wrap), .irq_o(irq));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // hang guard: far more cycles than the tests need
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic cycle: hold until ack is sampled, take data at that edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h000000, d}};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) bad_count++;
    q = rdat;
    req <= '0;
  endtask
  task automatic wrd(input logic [4:0] a, input logic [7:0] d, input logic [31:0] e);
    bus(1'b1, a, d);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one-cycle strobe from the core at top and or bottom, then the wrap pulse it should cause
  task automatic edge_hit(input logic t, input logic b, input logic w);
    @(posedge mclk);
    {top, bot} <= {t, b};
    @(posedge mclk);
    {top, bot} <= 2'b00;
    #1;
    chk(wrap, w);
  endtask
  task automatic t_regs;
    wrd(5'h00, 8'hff, 32'h0f);
    wrd(5'h04, 8'hff, 32'hf7);
    wrd(5'h0c, 8'hff, 32'hff);
    wrd(5'h18, 8'hff, 32'h00);
    wrd(5'h00, 8'h00, 32'h00);
    $display("t_regs done");
  endtask
  task automatic t_mode;
    logic [6:0] e [8] = '{7'h14, 7'h74, 7'h00, 7'h4a, 7'h00, 7'h4d, 7'h4f, 7'h4b};
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 5'h04, 8'(i));
      step(1);
      chk(32'(mode), 32'(e[i]));
    end
    $display("t_mode done");
  endtask
  // free prescaler: any 1024 cycles hold exactly 1024/N enables, for every divider code
  task automatic t_clk;
    int n;
    int dv [8] = '{1, 1, 2, 4, 8, 64, 256, 1024};
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 5'h00, 8'(c));
      step(1);
      n = 0;
      repeat (1024) begin
        step(1);
        n += (cen === 1'b1);
      end
      chk(n, (c == 0) ? 0 : 1024 / dv[c]);
    end
    bus(1'b1, 5'h00, 8'h0b);
    p.pulse(3);
    #1;
    chk(cen, 1);
    step(1);
    chk(cen, 0);
    bus(1'b1, 5'h00, 8'h00);
    $display("t_clk done");
  endtask
  task automatic t_evt;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 5'h0c, {3'(i), 5'h0e});
      step(1);
      chk({capm, eact}, {1'(i == 1 || i == 5 || i == 6), 3'(i)});
    end
    bus(1'b1, 5'h04, 8'hf0);
    bus(1'b1, 5'h0c, 8'h2e);
    p.pulse(1);
    #1;
    chk(cev, 4'h8);
    p.pulse(6);
    #1;
    chk({capm, aev, cev}, 6'h31);
    bus(1'b1, 5'h0c, 8'h3e);
    p.pulse(6);
    #1;
    chk(cev, 4'h0);
    step(1);
    chk(cev, 4'h1);
    bus(1'b1, 5'h0c, 8'h0e);
    p.pulse(6);
    #1;
    chk(aev, 0);
    bus(1'b1, 5'h0c, 8'h20);
    p.pulse(0);
    #1;
    chk(aev, 0);
    $display("t_evt done");
  endtask
  // counter is stopped here, so forced levels show on enabled pins
  task automatic t_pin;
    wrd(5'h08, 8'hfa, 32'h0a);
    chk(wlev, 4'ha);
    bus(1'b1, 5'h0c, 8'h00);
    bus(1'b1, 5'h04, 8'h03);
    step(2);
    chk({ovr, pin}, 8'h05);
    bus(1'b1, 5'h04, 8'hf3);
    step(2);
    chk({ovr, pin}, 8'hfa);
    bus(1'b1, 5'h04, 8'hf0);
    step(2);
    chk({ovr, pin}, 8'h05);
    bus(1'b1, 5'h04, 8'hf3);
    bus(1'b1, 5'h0c, 8'h2e);
    step(2);
    chk({ovr, pin}, 8'h05);
    $display("t_pin done");
  endtask
  task automatic t_irq;
    bus(1'b1, 5'h0c, 8'h00);
    bus(1'b1, 5'h04, 8'h00);
    bus(1'b1, 5'h00, 8'h01);
    wnext <= 4'h6;
    bus(1'b1, 5'h14, 8'h01);
    edge_hit(1'b1, 1'b0, 1'b1);
    step(2);
    chk(irq, 1);
    // running: levels follow the core and a forced write is ignored
    wrd(5'h08, 8'h0f, 32'h06);
    // overflow only counts as an error while a capture action is selected
    bus(1'b1, 5'h0c, 8'h2e);
    @(posedge mclk);
    covf <= 1'b1;
    @(posedge mclk);
    covf <= 1'b0;
    wrd(5'h10, 8'h01, 32'h02);
    chk(irq, 0);
    bus(1'b1, 5'h04, 8'h03);
    edge_hit(1'b1, 1'b0, 1'b0);
    edge_hit(1'b0, 1'b1, 1'b1);
    step(1);
    chk(irq, 1);
    $display("t_irq done");
  endtask
  initial begin
    req = '0;
    rst_b = 1'b0;
    {top, bot, covf, wnext} = '0;
    {bad_count, samples_checked, cyc_n} = '0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_mode();
    t_clk();
    t_evt();
    t_pin();
    t_irq();
    print_verdict();
  end
endmodule
